/* File: sfs_sync_lock.v */
`include "sfs_defs.vh"
module sfs_sync_lock (
    input  wire       mclk,
    input  wire       rst_b,
    input  wire       comp_in,
    input  wire       vco_in,
    input  wire [1:0] ratio_sel,
    input  wire       trk_ready,
    output reg        trk_data_q,
    output reg        trk_clk_q,
    output reg        sync_q,
    output reg        ref_sync_q,
    output reg        pump_up_q,
    output reg        pump_dn_q,
    output reg        lock_q,
    output reg  [3:0] pos_en_q,
    output reg        preset_q
);
    // ======================================================
    // Input synchronisers: change counts when stages 2 and 3 agree
    reg [2:0] comp_s_q;
    reg [2:0] vco_s_q;
    reg       comp_q;
    reg       vco_q;
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            comp_s_q <= 3'h0;
            vco_s_q  <= 3'h0;
            comp_q   <= 1'b0;
            vco_q    <= 1'b0;
        end
        else
        begin
            comp_s_q <= {comp_s_q[1:0], comp_in};
            vco_s_q  <= {vco_s_q[1:0], vco_in};
            if (comp_s_q[1] == comp_s_q[2])
                comp_q <= comp_s_q[2];
            if (vco_s_q[1] == vco_s_q[2])
                vco_q <= vco_s_q[2];
        end
    end

    wire comp_d = (comp_s_q[1] == comp_s_q[2]) ? comp_s_q[2] : comp_q;
    wire comp_fall = comp_q & ~comp_d;
    wire vco_d = (vco_s_q[1] == vco_s_q[2]) ? vco_s_q[2] : vco_q;
    wire tick = vco_d & ~vco_q;

    // ======================================================
    // Sync separator: timed window after each trailing edge
    reg [`SFS_WIN_W-1:0] win_q;
    reg                  sync_raw_q;
    wire win_open = (win_q != {`SFS_WIN_W{1'b0}});
    wire sync_now = win_open & comp_q;
    wire sync_fall = sync_raw_q & ~sync_now;
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            win_q      <= {`SFS_WIN_W{1'b0}};
            sync_raw_q <= 1'b0;
        end
        else
        begin
            if (comp_fall)
                win_q <= `SFS_WIN_LEN;
            else if (win_open)
                win_q <= win_q - 1'b1;
            sync_raw_q <= sync_now;
        end
    end

    // ======================================================
    // Prescaled window decoder counter
    reg [`SFS_RATIO_W-1:0] ratio;
    always @*
    begin
        case (ratio_sel)
            `SFS_SEL_32:  ratio = `SFS_RATIO_32;
            `SFS_SEL_64:  ratio = `SFS_RATIO_64;
            `SFS_SEL_96:  ratio = `SFS_RATIO_96;
            default:      ratio = `SFS_RATIO_128;
        endcase
    end

    reg [`SFS_CNT_W-1:0] cnt_q;
    reg                  alt_q;
    reg                  cmp_arm_q;
    reg                  ref_seen_q;
    reg                  sync_seen_q;
    wire do_preset = sync_fall & ~alt_q;
    // Window spans end of count three to end of count five
    wire in_win = (cnt_q == `SFS_CNT_WIN_LO) | (cnt_q == `SFS_CNT_WIN_HI);
    wire ref_now = (cnt_q == `SFS_CNT_REF);
    wire ref_fall = ref_sync_q & ~ref_now;
    wire [`SFS_CNT_W-1:0] last = ratio - `SFS_CNT_ONE;

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q       <= `SFS_CNT_ZERO;
            alt_q       <= 1'b0;
            preset_q    <= 1'b0;
            ref_sync_q  <= 1'b0;
            cmp_arm_q   <= 1'b0;
            ref_seen_q  <= 1'b0;
            sync_seen_q <= 1'b0;
            pump_up_q   <= 1'b0;
            pump_dn_q   <= 1'b0;
            pos_en_q    <= 4'h0;
        end
        else
        begin
            preset_q   <= do_preset;
            ref_sync_q <= ref_now;
            if (sync_fall)
                alt_q <= ~alt_q;
            if (do_preset)
                cnt_q <= `SFS_CNT_PRESET;
            else if (tick)
                cnt_q <= (cnt_q == last) ? `SFS_CNT_ZERO
                                         : cnt_q + 1'b1;
            // Phase compare on frame after preset: first edge wins
            if (do_preset)
            begin
                cmp_arm_q   <= 1'b1;
                ref_seen_q  <= 1'b0;
                sync_seen_q <= 1'b0;
            end
            else if (cmp_arm_q)
            begin
                if (ref_fall & sync_fall)
                    cmp_arm_q <= 1'b0;
                else if (ref_fall & ~ref_seen_q)
                begin
                    ref_seen_q <= 1'b1;
                    if (sync_seen_q)
                        cmp_arm_q <= 1'b0;
                end
                else if (sync_fall & ~sync_seen_q)
                begin
                    sync_seen_q <= 1'b1;
                    if (ref_seen_q)
                        cmp_arm_q <= 1'b0;
                end
            end
            // Disk edge late: VCO fast, pump up while waiting
            pump_up_q <= cmp_arm_q & ref_seen_q & ~sync_seen_q;
            pump_dn_q <= cmp_arm_q & sync_seen_q & ~ref_seen_q;
            pos_en_q[0] <= (cnt_q >= `SFS_POS0_START) &
                           (cnt_q < `SFS_POS1_START);
            pos_en_q[1] <= (cnt_q >= `SFS_POS1_START) &
                           (cnt_q < `SFS_POS2_START);
            pos_en_q[2] <= (cnt_q >= `SFS_POS2_START) &
                           (cnt_q < `SFS_POS3_START);
            pos_en_q[3] <= (cnt_q >= `SFS_POS3_START) &
                           (cnt_q < `SFS_POS_END);
        end
    end

    // ======================================================
    // Lock detector, judged at every disk sync trailing edge
    reg [`SFS_LK_W-1:0] run_q;
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            run_q  <= `SFS_LK_ZERO;
            lock_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            sync_q <= sync_now;
            if (sync_fall)
            begin
                // Count frames that disagree with the present state
                if (in_win != lock_q)
                begin
                    if (run_q == `SFS_LK_MAX)
                    begin
                        lock_q <= in_win;
                        run_q  <= `SFS_LK_ZERO;
                    end
                    else
                        run_q <= run_q + 1'b1;
                end
                else
                    run_q <= `SFS_LK_ZERO;
            end
        end
    end

    // ======================================================
    // Track data: first pulse of each cell, no decoding
    reg cell_first_q;
    reg tog_q;
    wire f_valid;
    wire f_in_ready;
    wire [1:0] f_data;
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cell_first_q <= 1'b0;
            tog_q        <= 1'b0;
        end
        else
        begin
            // Slot 1 of each cell follows the counter wrap
            cell_first_q <= (cnt_q == `SFS_CNT_ONE);
            // Stall drop: toggle only when the buffer has room
            if (cell_first_q & comp_fall & f_in_ready)
                tog_q <= ~tog_q;
        end
    end

    // Gap after each word keeps the track clock a single pulse
    wire pop_ok = trk_ready & ~trk_clk_q;
    wire push = (cnt_q == `SFS_CNT_REF) & tick;
    wire out_valid;
    sfs_fifo #(
        .W  (`SFS_FIFO_W),
        .D  (`SFS_FIFO_D),
        .AW (`SFS_FIFO_AW)
    ) u_fifo (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .in_valid  (push),
        .in_ready  (f_in_ready),
        .in_data   ({tog_q, 1'b1}),
        .out_valid (out_valid),
        .out_ready (pop_ok),
        .out_data  (f_data)
    );

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trk_data_q <= 1'b0;
            trk_clk_q  <= 1'b0;
        end
        else
        begin
            trk_clk_q <= out_valid & pop_ok & f_data[0];
            if (out_valid & pop_ok)
                trk_data_q <= f_data[1];
        end
    end
endmodule

/* File: sfs_defs.vh */
`ifndef SFS_DEFS_VH
`define SFS_DEFS_VH

// ==========================================================
// Prescaler ratios (VCO clocks per frame)
`define SFS_RATIO_W      8
`define SFS_RATIO_32     8'h20
`define SFS_RATIO_64     8'h40
`define SFS_RATIO_96     8'h60
`define SFS_RATIO_128    8'h80
`define SFS_SEL_32       2'h0
`define SFS_SEL_64       2'h1
`define SFS_SEL_96       2'h2
`define SFS_SEL_128      2'h3

// ==========================================================
// Window decoder counts
`define SFS_CNT_W        8
`define SFS_CNT_ZERO     8'h00
`define SFS_CNT_ONE      8'h01
`define SFS_CNT_PRESET   8'h05
`define SFS_CNT_REF      8'h04
`define SFS_CNT_WIN_LO   8'h04
`define SFS_CNT_WIN_HI   8'h05
`define SFS_POS0_START   8'h08
`define SFS_POS_LEN      8'h04
`define SFS_POS1_START   8'h0C
`define SFS_POS2_START   8'h10
`define SFS_POS3_START   8'h14
`define SFS_POS_END      8'h18

// ==========================================================
// Sync separator and pump timing, in mclk cycles
`define SFS_WIN_W        4
`define SFS_WIN_LEN      4'h6
`define SFS_PUMP_LEN     4'h4

// ==========================================================
// Lock detector
`define SFS_LK_W         2
`define SFS_LK_MAX       2'h3
`define SFS_LK_ZERO      2'h0

// ==========================================================
// Output buffer
`define SFS_FIFO_W       2
`define SFS_FIFO_D       4
`define SFS_FIFO_AW      2

`endif

/* File: sfs_fifo.v */
module sfs_fifo #(
    parameter W  = 2,
    parameter D  = 4,
    parameter AW = 2
) (
    input  wire          mclk,
    input  wire          rst_b,
    input  wire          in_valid,
    output wire          in_ready,
    input  wire [W-1:0]  in_data,
    output wire          out_valid,
    input  wire          out_ready,
    output wire [W-1:0]  out_data
);
    reg [W-1:0]  mem [0:D-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0]   cnt_q;
    wire         push;
    wire         pop;

    assign in_ready  = (cnt_q != D[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge mclk)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push & ~pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop & ~push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

/* File: sfs_sync_lock_assertions.sv */
// ====================
// Port checker
module sfs_sync_lock_chk (
    input wire       mclk,
    input wire       rst_b,
    input wire       comp_in,
    input wire       trk_data_q,
    input wire       trk_clk_q,
    input wire       sync_q,
    input wire       pump_up_q,
    input wire       pump_dn_q,
    input wire       lock_q,
    input wire [3:0] pos_en_q,
    input wire       preset_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] comp_age_q;
    logic [3:0] fall_age_q;
    logic       sync_p_q;
    // Ages saturate so a long idle gap never wraps back into range
    always @(posedge mclk or negedge rst_b)
        if (!rst_b)
        begin
            comp_age_q <= 4'hF;
            fall_age_q <= 4'hF;
            sync_p_q   <= 1'b0;
        end
        else
        begin
            sync_p_q   <= sync_q;
            comp_age_q <= comp_in ? 4'h0
                : comp_age_q + {3'h0, ~&comp_age_q};
            fall_age_q <= (sync_p_q & ~sync_q) ? 4'h0
                : fall_age_q + {3'h0, ~&fall_age_q};
        end
    sequence lock_hold_s;
        lock_q [*8];
    endsequence
    sequence unlock_hold_s;
        !lock_q [*8];
    endsequence
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    enable_onehot_a: assert property ($onehot0(pos_en_q))
        else $error("two position enables at once");
    pump_excl_a: assert property (!(pump_up_q && pump_dn_q))
        else $error("pump up and down together");
    trk_toggle_a: assert property ($changed(trk_data_q)
        |-> ##[0:1] trk_clk_q) else $error("track data without clock");
    clk_pulse_a: assert property (trk_clk_q |=> !trk_clk_q)
        else $error("track clock too long");
    preset_pulse_a: assert property (preset_q |=> !preset_q)
        else $error("preset too long");
    preset_cause_a: assert property (preset_q
        |-> $fell(sync_q) || fall_age_q < 4'h6)
        else $error("preset without sync edge");
    sync_cause_a: assert property (sync_q |-> comp_age_q < 4'h9)
        else $error("sync without comparator pulse");
    lock_hold_a: assert property ($rose(lock_q) |-> lock_hold_s)
        else $error("lock dropped early");
    unlock_hold_a: assert property ($fell(lock_q)
        |-> unlock_hold_s) else $error("lock set early");
endmodule

/* File: sfs_servo_src.sv */
// ====================
// Servo pulse source
module sfs_servo_src (
    input  wire  mclk,
    output logic comp_in,
    output logic vco_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        comp_in = 1'b0;
        vco_in  = 1'b0;
    end
    // Pad ticks lead the frame so the disk edge drifts late at once
    task automatic frame(input int ticks, input int pad, input bit dbit);
        int p;
        for (int c = 0; c < (ticks + pad) * 4; c++)
        begin
            @(negedge mclk);
            p = c - pad * 4;
            vco_in = (c % 4) < 2;
            comp_in = p == 14 || p == 15 || p == 18 || p == 19
                || (dbit && (p == 5 || p == 6));
        end
    endtask
endmodule

/* File: testbench.sv */
// ====================
// Testbench
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk = 1'b0;
    logic       rst_b = 1'b0;
    logic [1:0] ratio_sel = 2'h0;
    logic       trk_ready = 1'b1;
    wire        comp_in;
    wire        vco_in;
    wire        trk_data_q;
    wire        trk_clk_q;
    wire        sync_q;
    wire        ref_sync_q;
    wire        pump_up_q;
    wire        pump_dn_q;
    wire        lock_q;
    wire  [3:0] pos_en_q;
    wire        preset_q;
    int         failures = 0;
    int         comparisons = 0;
    int         cycles = 0;
    int         presets = 0;
    int         syncs = 0;
    int         coins = 0;
    logic       ref_seen = 1'b0;
    logic       trk_exp = 1'b0;
    logic       trk_seen = 1'b0;
    logic       lock_seen = 1'b0;
    logic       sync_seen = 1'b0;
    logic       up_seen = 1'b0;
    logic [3:0] pos_seen = 4'h0;
    logic       trk_qu[$];
    logic       lock_qu[$];
    sfs_servo_src sfs_servo_src_inst (.mclk, .comp_in, .vco_in);
    sfs_sync_lock sfs_sync_lock_inst (.mclk, .rst_b, .comp_in, .vco_in,
        .ratio_sel, .trk_ready, .trk_data_q, .trk_clk_q, .sync_q,
        .ref_sync_q, .pump_up_q, .pump_dn_q, .lock_q, .pos_en_q,
        .preset_q);
    always #10 mclk = ~mclk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Only the driver knows when a data pulse goes out
    task automatic frames(input int n, input int pad, input bit data);
        bit b;
        repeat (n)
        begin
            b = data && ($urandom & 1);
            if (b)
            begin
                trk_exp = ~trk_exp;
                trk_qu.push_back(trk_exp);
            end
            sfs_servo_src_inst.frame(32 * (ratio_sel + 1), pad, b);
        end
    endtask
    // ====================
    // Output watcher
    always @(negedge mclk)
    begin
        cycles++;
        if (cycles > 80000)
        begin
            failures++;
            summarize();
        end
        if (rst_b === 1'b1 && trk_data_q !== trk_seen)
            check(trk_data_q,
                trk_qu.size() ? trk_qu.pop_front() : 1'bx);
        if (rst_b === 1'b1 && lock_q !== lock_seen)
            check(lock_q,
                lock_qu.size() ? lock_qu.pop_front() : 1'bx);
        presets += preset_q;
        syncs += sync_seen && !sync_q;
        coins += ref_seen && !ref_sync_q && sync_seen && !sync_q;
        ref_seen = ref_sync_q;
        pos_seen |= pos_en_q;
        up_seen |= pump_up_q;
        trk_seen = trk_data_q;
        lock_seen = lock_q;
        sync_seen = sync_q;
    end
    // ====================
    // Scenarios, one pass per prescale ratio
    initial
    begin
        void'($urandom(32'h4992));
        for (int r = 0; r < 4; r++)
        begin
            @(negedge mclk);
            rst_b = 1'b0;
            ratio_sel = r[1:0];
            trk_exp = 1'b0;
            repeat (3) @(negedge mclk);
            rst_b = 1'b1;
            repeat (4) @(negedge mclk);
            lock_qu.push_back(1'b1);
            frames(8, 0, 0);
            check(lock_q, 1);
            presets = 0;
            syncs = 0;
            coins = 0;
            pos_seen = 4'h0;
            frames(8, 0, 1);
            check(8'(presets), 4);
            check(8'(coins), 8);
            check(8'(syncs), 8);
            check(pos_seen, 4'hF);
            trk_ready = 1'b0;
            frames(5, 0, 0);
            trk_ready = 1'b1;
            frames(1, 0, 0);
            check(trk_data_q, trk_exp);
            up_seen = 1'b0;
            frames(3, 4, 0);
            check(lock_q, 1);
            check(up_seen, 1);
            lock_qu.push_back(1'b0);
            frames(2, 4, 0);
            check(lock_q, 0);
            lock_qu.push_back(1'b1);
            frames(2, 0, 0);
            check(lock_q, 0);
            frames(6, 0, 0);
            check(lock_q, 1);
            check(8'(trk_qu.size() + lock_qu.size()), 0);
        end
        summarize();
    end
endmodule
bind sfs_sync_lock sfs_sync_lock_chk sfs_sync_lock_chk_inst (.mclk,
    .rst_b, .comp_in, .trk_data_q, .trk_clk_q, .sync_q, .pump_up_q,
    .pump_dn_q, .lock_q, .pos_en_q, .preset_q);
